// ---- verilog/sls_serializer.sv ----
// 21-bit parallel to three-lane serial link transmitter with forwarded clock
//
// Behaviour
// - three 7-bit shifters, loaded in parallel, each shifted out on its own lane
// - 21 input bits per input clock cycle travel over three data lanes
// - all 21 data inputs captured into holding register at each input clock fall
// - multiplier locked to input clock unloads holding register in 7-bit slices
// - forwarded clock phase-locked to input clock at identical frequency
// - four differential outputs: three serial lanes plus forwarded clock
// - power-down low stops internal clock and turns all output drivers off
// - power-down low forces every internal register except the pin synchronisers to zero
// - multiplier tracks 3 percent centre spread at 50 kHz modulation
// - bits 0..6 appear in order, bit n at n sevenths after clock rise
// - forwarded clock high four bit times, low three, per cycle
// - relock about 1 ms after power-down release; clock low soon after entry
// - on power-down the device goes off and holds forwarded clock low
module sls_serializer
    import sls_pkg::*;
#(
    parameter int                  LOCK_CYCLES = LOCK_CYCLES_DEF,
    parameter logic [PERIOD_W-1:0] PERIOD_MIN  = PERIOD_MIN_DEF,
    parameter logic [PERIOD_W-1:0] PERIOD_MAX  = PERIOD_MAX_DEF,
    parameter logic [PERIOD_W-1:0] SSC_TOL     = SSC_TOL_DEF
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 input_clock,
    input  wire logic [WORD_BITS-1:0] parallel_data,
    input  wire logic                 power_down_clear_n,
    output logic      [LANES-1:0]     serialLaneP,
    output logic      [LANES-1:0]     serialLaneN,
    output logic                      forwardedClockP,
    output logic                      forwardedClockN,
    output logic                      driverEnable
);
    sls_regs_t            r;
    sls_regs_t            next_r;
    logic [WORD_BITS+1:0] pinSync;
    logic [WORD_BITS-1:0] dataSync;
    logic                 clkSync;
    logic                 pdnSync;
    logic                 fall;
    logic                 periodOk;
    logic [PERIOD_W-1:0]  drift;
    logic [PERIOD_W:0]    accSum;
    logic                 tick;
    logic [WORD_BITS-1:0] shifted;

    // =========================================================
    // pin synchronisers: clock, data and power-down all arrive from outside
    sls_sync #(
        .WIDTH (WORD_BITS + 2)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .async   ({power_down_clear_n, input_clock, parallel_data}),
        .synced  (pinSync)
    );

    assign dataSync = pinSync[WORD_BITS-1:0];
    assign clkSync  = pinSync[WORD_BITS];
    assign pdnSync  = pinSync[WORD_BITS+1];

    // =========================================================
    // input clock edge and period qualification
    assign fall  = r.clkPrev & ~clkSync;
    assign drift = (r.cnt >= r.period) ? (r.cnt - r.period) : (r.period - r.cnt);
    // drift tolerance lets a spread-spectrum clock stay locked
    assign periodOk = (r.cnt >= PERIOD_MIN) && (r.cnt <= PERIOD_MAX) && (drift <= SSC_TOL);

    // fractional bit-rate generator: seven ticks per measured period
    assign accSum = {1'b0, r.acc} + {1'b0, BIT_STEP};
    assign tick   = (accSum >= {1'b0, r.period});

    // =========================================================
    // per-lane shift: each 7-bit slice moves one place toward its lane pin
    genvar ln;
    generate
        for (ln = 0; ln < LANES; ln++) begin : g_lane
            assign shifted[ln*SLICE_BITS +: SLICE_BITS] =
                {1'b0, r.shift[ln*SLICE_BITS+1 +: SLICE_BITS-1]};
            // differential pair; both legs low while drivers are off
            assign serialLaneP[ln] = r.drive &  r.laneBits[ln];
            assign serialLaneN[ln] = r.drive & ~r.laneBits[ln];
        end
    endgenerate

    assign forwardedClockP = r.drive &  r.fwdClk;
    assign forwardedClockN = r.drive & ~r.fwdClk;
    assign driverEnable    = r.drive;

    // =========================================================
    // next-state logic
    always_comb begin
        next_r         = r;
        next_r.clkPrev = clkSync;
        next_r.cnt     = (r.cnt == PERIOD_SAT) ? r.cnt : r.cnt + 8'h01;
        next_r.drive   = (r.state == ST_LOCKED);
        if (fall) begin
            next_r.cnt    = 8'h01;
            next_r.period = r.cnt;
            next_r.hold   = dataSync;
        end
        case (r.state)
            ST_OFF: begin
                next_r.state   = ST_ACQUIRE;
                next_r.lockCnt = '0;
            end
            ST_ACQUIRE: begin
                // a lost or wild edge restarts the lock wait
                if ((fall && !periodOk) || r.cnt == PERIOD_SAT) begin
                    next_r.lockCnt = '0;
                end else if (r.lockCnt == LOCK_W'(LOCK_CYCLES - 1)) begin
                    next_r.state = ST_LOCKED;
                    // park on the last slot with the clock low: a stale slot index would
                    // otherwise tick the clock high before any input edge starts a frame
                    next_r.bitIdx   = LAST_BIT;
                    next_r.fwdClk   = 1'b0;
                    next_r.laneBits = '0;
                end else begin
                    next_r.lockCnt = r.lockCnt + 16'h0001;
                end
            end
            ST_LOCKED: begin
                if ((fall && !periodOk) || r.cnt == PERIOD_SAT) begin
                    next_r.state    = ST_ACQUIRE;
                    next_r.lockCnt  = '0;
                    next_r.fwdClk   = 1'b0;
                    next_r.laneBits = '0;
                    next_r.bitIdx   = LAST_BIT;
                end else if (fall) begin
                    // new frame: previous word goes into the shifters, bit 0 out
                    next_r.shift  = r.hold;
                    next_r.acc    = '0;
                    next_r.bitIdx = '0;
                    next_r.fwdClk = 1'b1;
                    for (int l = 0; l < LANES; l++) begin
                        next_r.laneBits[l] = r.hold[l*SLICE_BITS];
                    end
                end else if (tick) begin
                    next_r.acc = PERIOD_W'(accSum - {1'b0, r.period});
                    // stop at the last slot until the next input edge starts a frame
                    if (r.bitIdx < LAST_BIT) begin
                        next_r.bitIdx = r.bitIdx + 3'h1;
                        next_r.shift  = shifted;
                        next_r.fwdClk = ((r.bitIdx + 3'h1) < 3'(CLK_HIGH_BITS));
                        for (int l = 0; l < LANES; l++) begin
                            next_r.laneBits[l] = r.shift[l*SLICE_BITS+1];
                        end
                    end
                end else begin
                    next_r.acc = PERIOD_W'(accSum);
                end
            end
            default: begin
                next_r = '0;
            end
        endcase
        // power-down clears everything and freezes the bit clock
        if (!pdnSync) begin
            next_r = '0;
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_off_clears_all: assert property (!pdnSync |=> (r == '0))
        else $error("state not cleared in power-down");

    a_off_drivers_low: assert property (!pdnSync |=> (!driverEnable && !forwardedClockP))
        else $error("drivers active in power-down");

    a_hold_on_fall: assert property ((fall && pdnSync) |=> (r.hold == $past(dataSync)))
        else $error("holding register missed the falling edge");

    a_lock_after_wait: assert property ($rose(r.state == ST_LOCKED)
            |-> ($past(r.lockCnt) == LOCK_W'(LOCK_CYCLES - 1)))
        else $error("lock declared before the wait elapsed");

    a_frame_starts: assert property ((r.state == ST_LOCKED && fall && periodOk
            && r.cnt != PERIOD_SAT && pdnSync)
            |=> (r.bitIdx == 3'h0 && r.fwdClk && driverEnable))
        else $error("frame did not start at bit 0 with clock high");

    a_lane_slices: assert property ((r.state == ST_LOCKED && fall && periodOk
            && r.cnt != PERIOD_SAT && pdnSync)
            |=> (r.laneBits == {$past(r.hold[2*SLICE_BITS]), $past(r.hold[SLICE_BITS]), $past(r.hold[0])}))
        else $error("lane slice mapping wrong");

    a_clock_duty: assert property ((r.state == ST_LOCKED && r.drive)
            |-> (forwardedClockP == (r.bitIdx < 3'(CLK_HIGH_BITS))))
        else $error("forwarded clock duty wrong");

    a_bit_advance: assert property ((r.state == ST_LOCKED && tick && !fall && pdnSync
            && r.cnt != PERIOD_SAT && r.bitIdx < LAST_BIT)
            |=> (r.bitIdx == $past(r.bitIdx) + 3'h1))
        else $error("bit slot did not advance on tick");

    a_clock_rise_edge: assert property ($rose(r.fwdClk) |-> $past(fall))
        else $error("forwarded clock rose off the input edge");

    c_locked: cover property ($rose(r.state == ST_LOCKED));
    c_last_bit: cover property (r.state == ST_LOCKED && r.bitIdx == LAST_BIT);
    c_off_while_locked: cover property (r.state == ST_LOCKED ##1 !pdnSync);
endmodule

// ---- verilog/sls_pkg.sv ----
// shared constants and types for the 21-to-3 lane serializer
package sls_pkg;
    // =========================================================
    // link shape
    localparam int LANES      = 3;
    localparam int SLICE_BITS = 7;
    localparam int WORD_BITS  = LANES * SLICE_BITS;
    localparam int CLK_HIGH_BITS = 4;           // forwarded clock high for bit slots 0..3

    // =========================================================
    // timing
    localparam int REF_CLK_MHZ     = 25;
    localparam int LOCK_TIME_US    = 1000;      // typical relock time after power-up
    localparam int LOCK_CYCLES_DEF = LOCK_TIME_US * REF_CLK_MHZ;
    localparam int PERIOD_W        = 8;         // input clock period, in reference cycles
    localparam int LOCK_W          = 16;

    localparam logic [PERIOD_W-1:0] PERIOD_MIN_DEF = 8'h04;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX_DEF = 8'h40;
    localparam logic [PERIOD_W-1:0] SSC_TOL_DEF    = 8'h01;  // period drift allowed per cycle
    localparam logic [PERIOD_W-1:0] PERIOD_SAT     = 8'hFF;
    localparam logic [PERIOD_W-1:0] BIT_STEP       = 8'h07;  // one slice per lane per period
    localparam logic [2:0]          LAST_BIT       = 3'h6;

    // =========================================================
    // multiplier state, gray coded along off -> acquire -> locked
    typedef enum logic [1:0] {
        ST_OFF     = 2'h0,
        ST_ACQUIRE = 2'h1,
        ST_LOCKED  = 2'h3
    } sls_state_t;

    typedef struct packed {
        sls_state_t            state;
        logic                  clkPrev;
        logic [PERIOD_W-1:0]   cnt;
        logic [PERIOD_W-1:0]   period;
        logic [PERIOD_W-1:0]   acc;
        logic [LOCK_W-1:0]     lockCnt;
        logic [2:0]            bitIdx;
        logic [WORD_BITS-1:0]  hold;
        logic [WORD_BITS-1:0]  shift;
        logic [LANES-1:0]      laneBits;
        logic                  fwdClk;
        logic                  drive;
    } sls_regs_t;
endpackage

// ---- verilog/sls_sync.sv ----
// two-stage synchroniser for a bundle of pin inputs
module sls_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta;

    // =========================================================
    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta   <= '0;
            synced <= '0;
        end else begin
            meta   <= async;
            synced <= meta;
        end
    end
endmodule

// ---- bench/sls_rx_model.sv ----
// behavioural panel receiver that rebuilds 21-bit words from the lanes
module sls_rx_model
    import sls_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic [LANES-1:0]     serialLaneP,
    input  wire logic [LANES-1:0]     serialLaneN,
    input  wire logic                 forwardedClockP,
    input  wire logic                 forwardedClockN,
    output logic      [WORD_BITS-1:0] rxWord,
    output int                        rxCount,
    output int                        shapeErr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WORD_BITS-1:0] acc = '0;
    logic                 prevClk = 1'b0;
    int                   k = 99;
    int                   n;
    // slot k after the clock rise holds bit k-1, slot 0 and 1 hold bit 0
    always @(posedge ref_clk) begin
        if (!(forwardedClockP | forwardedClockN)) begin
            k = 99; // drivers off: forget frame position
        end else begin
            if (forwardedClockP === forwardedClockN || serialLaneP !== ~serialLaneN) shapeErr++;
            if (forwardedClockP && !prevClk) begin
                if (k != 7 && k != 99) shapeErr++;
                k = 0;
            end else if (k != 99) begin
                k++;
            end
            if (k <= 7 && forwardedClockP !== (k <= 4)) shapeErr++;
            n = (k == 0) ? 0 : k - 1;
            if (k <= 7 && k != 1) begin
                for (int l = 0; l < LANES; l++) acc[l*SLICE_BITS+n] = serialLaneP[l];
            end
            if (k == 7) begin
                rxWord = acc;
                rxCount++;
            end
        end
        prevClk = forwardedClockP;
    end
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the three-lane serializer
module tb_top
    import sls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 ref_clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 inputClock = 1'b0;
    logic [WORD_BITS-1:0] parallelData = '0;
    logic                 powerDownClearN = 1'b1;
    logic [LANES-1:0]     serialLaneP, serialLaneN;
    logic                 forwardedClockP, forwardedClockN, driverEnable;
    logic [WORD_BITS-1:0] rxWord;
    int                   rxCount, shapeErr, errCount = 0, checked = 0, cycles = 0;
    logic [2:0]           phase = '0;
    logic [WORD_BITS-1:0] rxLog[$];

    sls_serializer #(.LOCK_CYCLES(20)) dut_u (.ref_clk(ref_clk), .reset(reset), .input_clock(inputClock),
        .parallel_data(parallelData), .power_down_clear_n(powerDownClearN), .serialLaneP(serialLaneP),
        .serialLaneN(serialLaneN), .forwardedClockP(forwardedClockP), .forwardedClockN(forwardedClockN),
        .driverEnable(driverEnable));
    sls_rx_model rx_u (.ref_clk(ref_clk), .serialLaneP(serialLaneP), .serialLaneN(serialLaneN),
        .forwardedClockP(forwardedClockP), .forwardedClockN(forwardedClockN), .rxWord(rxWord),
        .rxCount(rxCount), .shapeErr(shapeErr));

    // =========================================================
    // clocks: input clock is 8 reference cycles, half high
    always #20 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        phase <= phase + 3'h1;
        inputClock <= phase[2];
    end
    always @(rxCount) rxLog.push_back(rxWord);
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            completeRun();
        end
    end

    // =========================================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        if (errCount == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [WORD_BITS-1:0] expWord(input int i);
        return (i < WORD_BITS) ? 21'h000001 << i : (i == WORD_BITS) ? 21'h1FFFFF : 21'h0AAAAA;
    endfunction
    task automatic sendWord(input logic [WORD_BITS-1:0] w);
        @(posedge inputClock);
        parallelData <= w;
    endtask
    task automatic waitLock();
        int n = 0;
        while (driverEnable !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        check(driverEnable, 1'b1);
    endtask
    task automatic outputsOff();
        check({serialLaneP, serialLaneN, forwardedClockP, forwardedClockN, driverEnable}, '0);
    endtask

    // =========================================================
    // scenarios
    task automatic testReset();
        repeat (6) @(negedge ref_clk);
        outputsOff();
        reset <= 1'b0;
        repeat (8) @(negedge ref_clk);
        check(driverEnable, 1'b0);
        waitLock();
    endtask
    // walking one, all ones and alternating words, sent back to back
    task automatic testStream();
        int j = -1;
        for (int i = 0; i < WORD_BITS + 2; i++) sendWord(expWord(i));
        repeat (4) sendWord('0);
        foreach (rxLog[q]) if (j < 0 && rxLog[q] === expWord(0)) j = q;
        check(j >= 0, 1'b1);
        for (int i = 1; i < WORD_BITS + 2; i++) check(rxLog[j+i], expWord(i));
        check(shapeErr, 0);
    endtask
    // power-down in mid-stream, then recovery with a fresh word
    task automatic testPowerDown();
        int seen;
        logic busy = 1'b0;
        sendWord(21'h15A5A5);
        powerDownClearN <= 1'b0;
        repeat (6) @(negedge ref_clk);
        outputsOff();
        seen = rxLog.size();
        repeat (40) begin
            @(negedge ref_clk);
            busy |= |{serialLaneP, serialLaneN, forwardedClockP, forwardedClockN, driverEnable};
        end
        check(busy, 1'b0);
        check(rxLog.size(), seen);
        powerDownClearN <= 1'b1;
        waitLock();
        repeat (4) sendWord(21'h0F0F33);
        check(rxLog[$], 21'h0F0F33);
        check(shapeErr, 0);
    endtask

    initial begin
        testReset();
        testStream();
        testPowerDown();
        completeRun();
    end
endmodule
